// >>> core/bil_pkg.sv
// boot image loader package: constants, fetch and status carriers, crc step
// assumes a single 250 MHz core clock and a byte-wide fetch partner on the link clock
package bil_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned INT_RST_NS    = 15000;
    localparam int unsigned INT_RST_CYC   = (INT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_CNT_W     = 12;

    // ------------------------------------------------------------------
    // image format and crc
    // ------------------------------------------------------------------
    localparam logic [31:0] CRC_POLY        = 32'hEDB88320;
    localparam logic [31:0] CRC_INIT        = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_BYPASS      = 32'h0D15AB1E;
    localparam int unsigned SEC_OTP_BOOT_BIT = 5;
    localparam logic [31:0] RAM_BASE        = 32'h00000000;

    // ------------------------------------------------------------------
    // source addresses (byte addresses within each source)
    // ------------------------------------------------------------------
    localparam logic [23:0] SEC_REG_ADDR    = 24'h000000;
    localparam logic [23:0] OTP_IMG_ADDR    = 24'h000000;
    localparam logic [23:0] FLASH_IMG_ADDR  = 24'h000000;
    localparam int unsigned GPIO_W_DEF      = 33;
    localparam int unsigned RAM_WORDS_DEF   = 65536;

    typedef enum logic [1:0] {
        BIL_SRC_FLASH  = 2'b00,
        BIL_SRC_OTP    = 2'b01,
        BIL_SRC_SECREG = 2'b10
    } bil_src_e;

    typedef enum logic [2:0] {
        BIL_ST_RST  = 3'b000,
        BIL_ST_SEC  = 3'b001,
        BIL_ST_LEN  = 3'b010,
        BIL_ST_BODY = 3'b011,
        BIL_ST_CHK  = 3'b100,
        BIL_ST_RUN  = 3'b101,
        BIL_ST_FAIL = 3'b110
    } bil_state_e;

    typedef struct packed {
        bil_src_e    sel;
        logic [23:0] addr;
    } bil_fetch_s;

    typedef struct packed {
        logic        busy;
        logic        run;
        logic [31:0] start_addr;
        logic        from_otp;
        logic        crc_err;
        logic        size_err;
    } bil_stat_s;

    // one byte through the reflected crc, low bit first
    function automatic logic [31:0] bil_crc_byte(input logic [31:0] crc, input logic [7:0] d);
        logic [31:0] c;
        c = crc ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

endpackage

// >>> core/bil_ram.sv
// boot image loader program ram: one word write port, one registered read port
// assumes writer and reader share the core clock
`timescale 1ns/1ns
module bil_ram #(
    parameter int unsigned WORDS = 65536,
    parameter int unsigned AW    = 16
) (
    // clock
    input  wire logic          ref_clk,
    // write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [31:0]   wr_data,
    // read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [31:0]   rd_data_r
);

    logic [31:0] mem [WORDS];

    if (WORDS < 2 || (1 << AW) < WORDS) begin : g_bad_size
        $error("bil_ram: address width cannot reach every word");
    end

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read data from a flop so the array maps onto block ram
    always_ff @(posedge ref_clk) begin
        rd_data_r <= mem[rd_addr];
    end

endmodule // bil_ram

// >>> core/bil_loader.sv
// boot image loader: reset phase, security word fetch, image parse, crc check, start
// assumes a byte fetch partner (flash or otp) clocked by lnk_clk with a req/ack handshake
//
// Overview of operation
// - device stays in reset while rst_n low
// - all gpio pull-downs on during reset
// - internal reset phase before boot begins
// - default boot source is embedded quad-spi flash
// - security bit 5 selects otp, else flash
// - read word count, then count times four bytes
// - check word 0x0D15AB1E skips crc test
// - length and check word little-endian byte order
// - program stored from lowest ram address up
// - execution starts at lowest ram address
// - crc covers length bytes and program bytes
// - reflected crc polynomial 0xEDB88320
// - crc register preset to all ones
// - final crc inverted before compare
// - otp boot reads image from otp address zero
// - security word loaded from security register before decision
`timescale 1ns/1ns
module bil_loader
    import bil_pkg::*;
#(
    parameter int unsigned GPIO_W    = GPIO_W_DEF,
    parameter int unsigned RAM_WORDS = RAM_WORDS_DEF
) (
    // core clock and chip reset
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    // link clock and fetch partner
    input  wire logic               lnk_clk,
    output bil_fetch_s              src_fetch_r,
    output logic                    src_req_r,
    input  wire logic               src_ack,
    input  wire logic [7:0]         src_data,
    // pad control
    output logic [GPIO_W-1:0]       gpio_pd_en_r,
    // boot status
    output bil_stat_s               stat,
    // processor read port into program ram
    input  wire logic [31:0]        cpu_rd_addr,
    output logic      [31:0]        cpu_rd_data
);

    localparam int unsigned AW = $clog2(RAM_WORDS);

    if (GPIO_W < 1 || RAM_WORDS < 2 || INT_RST_CYC >= (1 << RST_CNT_W)) begin : g_bad_cfg
        $error("bil_loader: parameters out of range");
    end

    // ------------------------------------------------------------------
    // core domain registers
    // ------------------------------------------------------------------
    bil_state_e           state_r;
    bil_state_e           state_nxt;
    logic [RST_CNT_W-1:0] rst_cnt_r;
    logic                 req_tgl_r;
    logic                 pend_r;
    bil_fetch_s           fetch_r;
    logic [1:0]           byte_idx_r;
    logic [31:0]          word_sh_r;
    logic [31:0]          len_r;
    logic [31:0]          widx_r;
    logic [31:0]          crc_r;
    logic                 from_otp_r;
    logic                 crc_err_r;
    logic                 size_err_r;
    logic                 ack_s1_r;
    logic                 ack_s2_r;
    logic                 ack_seen_r;

    // ------------------------------------------------------------------
    // link domain registers
    // ------------------------------------------------------------------
    logic                 lnk_rst_q_r;
    logic                 lnk_rst_n_r;
    logic                 lnk_req_s1_r;
    logic                 lnk_req_s2_r;
    logic                 lnk_req_seen_r;
    logic                 lnk_ack_tgl_r;
    logic [7:0]           lnk_data_r;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire logic        fetching  = (state_r == BIL_ST_SEC) || (state_r == BIL_ST_LEN) ||
                                  (state_r == BIL_ST_BODY) || (state_r == BIL_ST_CHK);
    wire logic        issue     = fetching && !pend_r;
    wire logic        byte_vld  = ack_s2_r ^ ack_seen_r;
    wire logic [31:0] word_now  = {lnk_data_r, word_sh_r[31:8]};
    wire logic        word_done = byte_vld && (byte_idx_r == 2'b11);
    wire logic        crc_upd   = byte_vld &&
                                  ((state_r == BIL_ST_LEN) || (state_r == BIL_ST_BODY));
    wire logic [31:0] crc_step  = bil_crc_byte(crc_r, lnk_data_r);
    wire logic        sec_otp   = word_now[SEC_OTP_BOOT_BIT];
    wire logic        too_big   = {1'b0, word_now} > {1'b0, RAM_WORDS[31:0]};
    wire logic        body_last = (widx_r + 32'h00000001) == len_r;
    wire logic        crc_ok    = (word_now == CRC_BYPASS) || (word_now == ~crc_r);
    wire logic        ram_we    = word_done && (state_r == BIL_ST_BODY);
    wire logic        rst_done  = rst_cnt_r == RST_CNT_W'(INT_RST_CYC - 1);

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            BIL_ST_RST: begin
                if (rst_done) begin
                    state_nxt = BIL_ST_SEC;
                end
            end
            BIL_ST_SEC: begin
                if (word_done) begin
                    state_nxt = BIL_ST_LEN;
                end
            end
            BIL_ST_LEN: begin
                if (word_done) begin
                    if (too_big) begin
                        state_nxt = BIL_ST_FAIL;
                    end else if (word_now == 32'h00000000) begin
                        state_nxt = BIL_ST_CHK;
                    end else begin
                        state_nxt = BIL_ST_BODY;
                    end
                end
            end
            BIL_ST_BODY: begin
                if (word_done && body_last) begin
                    state_nxt = BIL_ST_CHK;
                end
            end
            BIL_ST_CHK: begin
                if (word_done) begin
                    state_nxt = crc_ok ? BIL_ST_RUN : BIL_ST_FAIL;
                end
            end
            BIL_ST_RUN: begin
                state_nxt = BIL_ST_RUN;
            end
            BIL_ST_FAIL: begin
                state_nxt = BIL_ST_FAIL;
            end
            default: begin
                state_nxt = BIL_ST_FAIL;
            end
        endcase
    end

    // holding the whole loader in reset is all that rst_n needs to do
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= BIL_ST_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_r <= '0;
        end else if (state_r == BIL_ST_RST) begin
            rst_cnt_r <= rst_cnt_r + RST_CNT_W'(1);
        end
    end

    // pull-downs stay on through the internal reset phase, released at first fetch
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_pd_en_r <= '1;
        end else if (state_r != BIL_ST_RST) begin
            gpio_pd_en_r <= '0;
        end
    end

    // ------------------------------------------------------------------
    // fetch request side
    // ------------------------------------------------------------------
    // one byte outstanding at a time; fetch_r holds still until its byte is back,
    // so the link side may sample it as soon as it sees the toggle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_tgl_r <= 1'b0;
            pend_r    <= 1'b0;
        end else if (issue) begin
            req_tgl_r <= ~req_tgl_r;
            pend_r    <= 1'b1;
        end else if (byte_vld) begin
            pend_r    <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_r <= '{sel: BIL_SRC_SECREG, addr: SEC_REG_ADDR};
        end else if (word_done && state_r == BIL_ST_SEC) begin
            fetch_r <= sec_otp ? '{sel: BIL_SRC_OTP,   addr: OTP_IMG_ADDR}
                               : '{sel: BIL_SRC_FLASH, addr: FLASH_IMG_ADDR};
        end else if (byte_vld) begin
            fetch_r.addr <= fetch_r.addr + 24'h000001;
        end
    end

    // ------------------------------------------------------------------
    // byte assembly and crc
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_idx_r <= 2'b00;
            word_sh_r  <= '0;
        end else if (byte_vld) begin
            byte_idx_r <= byte_idx_r + 2'b01;
            word_sh_r  <= word_now;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_r <= CRC_INIT;
        end else if (crc_upd) begin
            crc_r <= crc_step;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            len_r      <= '0;
            from_otp_r <= 1'b0;
        end else if (word_done && state_r == BIL_ST_SEC) begin
            from_otp_r <= sec_otp;
        end else if (word_done && state_r == BIL_ST_LEN) begin
            len_r      <= word_now;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            widx_r <= '0;
        end else if (ram_we) begin
            widx_r <= widx_r + 32'h00000001;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_err_r  <= 1'b0;
            size_err_r <= 1'b0;
        end else if (word_done && state_r == BIL_ST_CHK && !crc_ok) begin
            crc_err_r  <= 1'b1;
        end else if (word_done && state_r == BIL_ST_LEN && too_big) begin
            size_err_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // program ram
    // ------------------------------------------------------------------
    // the processor port only reads; loading owns the write side
    bil_ram #(
        .WORDS     (RAM_WORDS),
        .AW        (AW)
    ) u_ram (
        .ref_clk   (ref_clk),
        .wr_en     (ram_we),
        .wr_addr   (widx_r[AW-1:0]),
        .wr_data   (word_now),
        .rd_addr   (cpu_rd_addr[AW-1:0]),
        .rd_data_r (cpu_rd_data)
    );

    // ------------------------------------------------------------------
    // status
    // ------------------------------------------------------------------
    assign stat.busy       = (state_r != BIL_ST_RUN) && (state_r != BIL_ST_FAIL);
    assign stat.run        = state_r == BIL_ST_RUN;
    assign stat.start_addr = RAM_BASE;
    assign stat.from_otp   = from_otp_r;
    assign stat.crc_err    = crc_err_r;
    assign stat.size_err   = size_err_r;

    // ------------------------------------------------------------------
    // crossing: byte-done toggle into the core domain
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_s1_r   <= 1'b0;
            ack_s2_r   <= 1'b0;
            ack_seen_r <= 1'b0;
        end else begin
            ack_s1_r   <= lnk_ack_tgl_r;
            ack_s2_r   <= ack_s1_r;
            ack_seen_r <= ack_s2_r;
        end
    end

    // ------------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------------
    // reset asserts at once, releases two link edges later
    always_ff @(posedge lnk_clk or negedge rst_n) begin
        if (!rst_n) begin
            lnk_rst_q_r <= 1'b0;
            lnk_rst_n_r <= 1'b0;
        end else begin
            lnk_rst_q_r <= 1'b1;
            lnk_rst_n_r <= lnk_rst_q_r;
        end
    end

    always_ff @(posedge lnk_clk or negedge lnk_rst_n_r) begin
        if (!lnk_rst_n_r) begin
            lnk_req_s1_r   <= 1'b0;
            lnk_req_s2_r   <= 1'b0;
            lnk_req_seen_r <= 1'b0;
        end else begin
            lnk_req_s1_r   <= req_tgl_r;
            lnk_req_s2_r   <= lnk_req_s1_r;
            lnk_req_seen_r <= lnk_req_s2_r;
        end
    end

    wire logic lnk_new_req = lnk_req_s2_r ^ lnk_req_seen_r;
    wire logic lnk_take    = src_req_r && src_ack;

    // partner bytes are captured here and held until the next request,
    // which cannot start before the core has consumed this one
    always_ff @(posedge lnk_clk or negedge lnk_rst_n_r) begin
        if (!lnk_rst_n_r) begin
            src_req_r     <= 1'b0;
            src_fetch_r   <= '{sel: BIL_SRC_SECREG, addr: SEC_REG_ADDR};
            lnk_data_r    <= 8'h00;
            lnk_ack_tgl_r <= 1'b0;
        end else if (lnk_new_req) begin
            src_req_r     <= 1'b1;
            src_fetch_r   <= fetch_r;
        end else if (lnk_take) begin
            src_req_r     <= 1'b0;
            lnk_data_r    <= src_data;
            lnk_ack_tgl_r <= ~lnk_ack_tgl_r;
        end
    end

endmodule // bil_loader

// >>> sim/bil_loader_sva.sv
// checker for the boot image loader ports
// assumes it is bound into every loader instance
`timescale 1ns/1ns
module bil_loader_sva
    import bil_pkg::*;
#(
    parameter int unsigned GPIO_W = GPIO_W_DEF
) (
    // clocks and reset
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic              lnk_clk,
    // link
    input wire bil_fetch_s        src_fetch_r,
    input wire logic              src_req_r,
    input wire logic              src_ack,
    // pads and status
    input wire logic [GPIO_W-1:0] gpio_pd_en_r,
    input wire bil_stat_s         stat
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    logic [11:0] up_cyc_r;
    logic [1:0]  last_sel_r;
    logic [23:0] last_addr_r;

    // saturates so a long run cannot wrap back into the reset phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) up_cyc_r <= 12'h000;
        else if (up_cyc_r != 12'hFFF) up_cyc_r <= up_cyc_r + 12'h001;
    end

    // all ones so that the first byte of a source must sit at address zero
    always_ff @(posedge lnk_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_sel_r  <= BIL_SRC_SECREG;
            last_addr_r <= 24'hFFFFFF;
        end else if (src_req_r && src_ack) begin
            last_sel_r  <= src_fetch_r.sel;
            last_addr_r <= src_fetch_r.addr;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    pd_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        up_cyc_r < 12'(INT_RST_CYC) |-> &gpio_pd_en_r) else $error("pull-downs dropped early");
    fetch_late_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        src_req_r |-> up_cyc_r >= 12'(INT_RST_CYC - 1)) else $error("fetch before reset phase");
    pd_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        up_cyc_r == 12'hFFF |-> !(&gpio_pd_en_r)) else $error("boot never began");
    req_hold_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        src_req_r && !src_ack |=> src_req_r && $stable(src_fetch_r)) else $error("request moved");
    req_drop_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        src_req_r && src_ack |=> !src_req_r) else $error("request not dropped");
    addr_step_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        $rose(src_req_r) |-> src_fetch_r.addr == ((src_fetch_r.sel == last_sel_r) ?
        last_addr_r + 24'h000001 : 24'h000000)) else $error("fetch address gap");
    sec_first_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        $rose(src_req_r) && src_fetch_r.sel != BIL_SRC_SECREG |->
        last_sel_r != BIL_SRC_SECREG || last_addr_r == 24'h000003) else $error("short sec word");
    run_ok_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stat.run |-> !stat.busy && !stat.crc_err && !stat.size_err && stat.start_addr == RAM_BASE)
        else $error("bad run status");
    err_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(stat.crc_err) |=> stat.crc_err [*8]) else $error("crc error not sticky");
    idle_why_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !stat.busy |-> stat.run || stat.crc_err || stat.size_err) else $error("idle without cause");

    run_otp_c: cover property (@(posedge ref_clk) $rose(stat.run) && stat.from_otp);
    run_fl_c: cover property (@(posedge ref_clk) $rose(stat.run) && !stat.from_otp);
    crc_c: cover property (@(posedge ref_clk) $rose(stat.crc_err));
    size_c: cover property (@(posedge ref_clk) $rose(stat.size_err));
endmodule // bil_loader_sva

bind bil_loader bil_loader_sva #(.GPIO_W(GPIO_W)) u_sva (.ref_clk(ref_clk), .rst_n(rst_n),
    .lnk_clk(lnk_clk), .src_fetch_r(src_fetch_r), .src_req_r(src_req_r), .src_ack(src_ack),
    .gpio_pd_en_r(gpio_pd_en_r), .stat(stat));

// >>> sim/bil_src_model.sv
// far-side model: security word, otp and flash image bytes on the link clock
// assumes one byte outstanding; the bench loads contents hierarchically
`timescale 1ns/1ns
module bil_src_model
    import bil_pkg::*;
(
    // link
    input  wire logic       lnk_clk,
    input  wire bil_fetch_s src_fetch_r,
    input  wire logic       src_req_r,
    output logic            src_ack,
    output logic [7:0]      src_data
);
    logic [31:0] sec_word;
    logic [7:0]  img_mem [2][64];
    bil_src_e    img_sel;
    int          img_cnt = 0;
    int          sec_cnt = 0;
    int          pseed = 32'h1D7;
    logic [7:0]  pick;

    // security word low byte first; otp and flash both start at address zero
    assign pick = (src_fetch_r.sel == BIL_SRC_SECREG) ? sec_word[8*src_fetch_r.addr[1:0] +: 8]
        : (src_fetch_r.addr < 24'h000040) ? img_mem[src_fetch_r.sel[0]][src_fetch_r.addr[5:0]]
        : ~src_fetch_r.addr[7:0];

    initial begin
        src_ack  = 1'b0;
        src_data = 8'hA5;
    end

    // answers after a random wait, so prompt and slow replies both occur
    always @(posedge lnk_clk) begin
        if (!src_req_r) src_ack <= 1'b0;
        else if (src_ack) begin
            src_ack  <= 1'b0;
            src_data <= ~src_data;
            if (src_fetch_r.sel == BIL_SRC_SECREG) sec_cnt <= sec_cnt + 1;
            else begin
                img_cnt <= img_cnt + 1;
                img_sel <= bil_src_e'(src_fetch_r.sel);
            end
        end else if ($random(pseed) % 3 == 0) begin
            src_ack  <= 1'b1;
            src_data <= pick;
        end
    end
endmodule // bil_src_model

// >>> sim/boot_image_loader_tb_top.sv
// bench top: boots the loader from flash and otp images, checks status and ram
// assumes the far-side model and the bound checker
`timescale 1ns/1ns
module boot_image_loader_tb_top import bil_pkg::*;;
    logic        ref_clk = 1'b0;
    logic        lnk_clk = 1'b0;
    logic        rst_n = 1'b0;
    bil_fetch_s  src_fetch_r;
    logic        src_req_r;
    logic        src_ack;
    logic [7:0]  src_data;
    logic [32:0] gpio_pd_en_r;
    bil_stat_s   stat;
    logic [31:0] cpu_rd_addr = 32'h00000000;
    logic [31:0] cpu_rd_data;
    int          errors = 0;
    int          checks_done = 0;
    int          seed = 32'he99a;
    logic [7:0]  img [$];

    initial forever #2 ref_clk = ~ref_clk;
    initial begin
        #37;
        forever #80 lnk_clk = ~lnk_clk;
    end

    bil_loader #(.GPIO_W(33)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .lnk_clk(lnk_clk),
        .src_fetch_r(src_fetch_r), .src_req_r(src_req_r), .src_ack(src_ack),
        .src_data(src_data), .gpio_pd_en_r(gpio_pd_en_r), .stat(stat),
        .cpu_rd_addr(cpu_rd_addr), .cpu_rd_data(cpu_rd_data));
    bil_src_model ptr (.lnk_clk(lnk_clk), .src_fetch_r(src_fetch_r), .src_req_r(src_req_r),
        .src_ack(src_ack), .src_data(src_data));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    function automatic logic [31:0] crc_of(input int n);
        logic [31:0] c;
        c = CRC_INIT;
        for (int i = 0; i < n; i++) begin
            c = c ^ {24'h000000, img[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return ~c;
    endfunction

    // mode 0 crc good, 1 bypass word, 2 crc corrupted, 3 length beyond ram
    task automatic boot(input logic otp, input int s, input int mode);
        logic [31:0] len;
        logic [31:0] cw;
        int          n;
        len = (mode == 3) ? 32'h00010001 : 32'(s);
        img.delete();
        for (int i = 0; i < 4; i++) img.push_back(len[8*i +: 8]);
        for (int i = 0; i < 4 * s; i++) img.push_back(8'($random(seed)));
        cw = (mode == 1) ? CRC_BYPASS : crc_of(img.size()) ^ ((mode == 2) ? 32'h00000100 : 32'h0);
        for (int i = 0; i < 4; i++) img.push_back(cw[8*i +: 8]);
        // the unused source holds inverted bytes, so a wrong pick cannot pass
        for (int i = 0; i < 64; i++) begin
            ptr.img_mem[otp][i]  = (i < img.size()) ? img[i] : 8'h5A;
            ptr.img_mem[!otp][i] = ~ptr.img_mem[otp][i];
        end
        ptr.sec_word = ($random(seed) & ~32'h00000020) | (otp ? 32'h00000020 : 32'h00000000);
        ptr.img_cnt = 0;
        ptr.sec_cnt = 0;
        rst_n = 1'b0;
        repeat (10) @(posedge lnk_clk);
        chk(gpio_pd_en_r, {33{1'b1}}, "pull-downs in reset");
        chk(stat.busy, 1'b1, "busy in reset");
        @(posedge ref_clk);
        #1 rst_n = 1'b1;
        n = 0;
        while (stat.busy === 1'b1 && n < 20000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(n >= INT_RST_CYC && n < 20000, 1'b1, "boot span");
        // long enough for a refused image to show any stray fetch
        repeat (500) @(posedge ref_clk);
        #1;
        chk(stat.run, mode < 2, "run");
        chk(stat.crc_err, mode == 2, "crc error");
        chk(stat.size_err, mode == 3, "size error");
        chk(stat.from_otp, otp, "from otp");
        chk(stat.start_addr, RAM_BASE, "start address");
        chk(ptr.sec_cnt, 4, "security bytes");
        chk(ptr.img_cnt, (mode == 3) ? 4 : img.size(), "image bytes");
        chk(ptr.img_sel, otp ? BIL_SRC_OTP : BIL_SRC_FLASH, "image source");
        for (int k = 0; k < s; k++) begin
            @(posedge ref_clk);
            #1 cpu_rd_addr = 32'(k);
            repeat (2) @(posedge ref_clk);
            #1 chk(cpu_rd_data, {img[4*k+7], img[4*k+6], img[4*k+5], img[4*k+4]}, "ram");
        end
    endtask

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        boot(1'b0, 3, 0);
        boot(1'b1, 3, 1);
        boot(1'b0, 2, 2);
        boot(1'b1, 0, 0);
        boot(1'b0, 0, 3);
        boot(1'($random(seed)), ($random(seed) & 1) + 1, 0);
        close_out();
    end

    initial begin
        repeat (90000) @(posedge ref_clk);
        errors++;
        close_out();
    end
endmodule // boot_image_loader_tb_top
